// >>> bbsram_cfg.svh
`ifndef BBSRAM_CFG_SVH
`define BBSRAM_CFG_SVH
// ***************************************************************
// widths
// ***************************************************************
`define BBS_ADDR_W        11
`define BBS_DATA_W        8
`define BBS_DATA_RESET    8'h00
`define BBS_ADDR_RESET    11'h000
// ***************************************************************
// timing, ns except power recovery in us, slowest grade; clock period 4 ns
// ***************************************************************
`define BBS_CLK_NS             4
`define BBS_CYCLE_NS           250
`define BBS_ACCESS_NS          250
`define BBS_GATE_FLOAT_NS      50
`define BBS_WRITE_FLOAT_NS     80
`define BBS_WRITE_PULSE_NS     160
`define BBS_DIN_SETUP_NS       100
`define BBS_RECOVERY_NS        10
`define BBS_POWER_REC_US       120
// least times round up
`define BBS_CYCLE_CYC      ((`BBS_CYCLE_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_ACCESS_CYC     ((`BBS_ACCESS_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_FLOAT_CYC      ((`BBS_WRITE_FLOAT_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_GFLOAT_CYC     ((`BBS_GATE_FLOAT_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_PULSE_CYC      ((`BBS_WRITE_PULSE_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_RECOVERY_CYC   ((`BBS_RECOVERY_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_POWER_REC_CYC  ((`BBS_POWER_REC_US * 1000 + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`endif

// >>> bbs_pkg.sv
package bbs_pkg;
  typedef enum logic [2:0] {
    BBS_IDLE    = 3'b000,
    BBS_RD_WAIT = 3'b001,
    BBS_WR_FLT  = 3'b010,
    BBS_WR_PULS = 3'b011,
    BBS_FLOAT   = 3'b100,
    BBS_RECOVER = 3'b101
  } bbs_state_type;
  typedef enum logic [1:0] {
    BBS_SUPPLY_NORMAL  = 2'b00,
    BBS_SUPPLY_FAIL    = 2'b01,
    BBS_SUPPLY_BATTERY = 2'b10
  } bbs_supply_type;
endpackage

// >>> bbs_delay_count.sv
// ***************************************************************
// loadable down counter, done when zero
// ***************************************************************
module bbs_delay_count #(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk, // clock
  input  wire logic             nrst,    // async reset, low
  input  wire logic             load,    // load pulse
  input  wire logic [WIDTH-1:0] value,   // load value
  output logic                  done     // count at zero
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done = (count == '0);
endmodule

// >>> bbs_host.sv
`include "bbsram_cfg.svh"
module bbs_host
  import bbs_pkg::*;
#(
  parameter int POWER_REC_CYC = `BBS_POWER_REC_CYC
) (
  input  wire logic                   sys_clk,      // 250 MHz clock
  input  wire logic                   nrst,         // async reset, low
  input  wire logic                   reqValid,     // user request
  input  wire logic                   reqWrite,     // 1 write, 0 read
  input  wire logic [`BBS_ADDR_W-1:0] reqAddr,      // user address
  input  wire logic [`BBS_DATA_W-1:0] reqData,      // user write byte
  input  wire logic [1:0]             supplyState,  // bbs_supply_type
  input  wire logic                   failWarn_n,   // power-fail warning, low
  input  wire logic [`BBS_DATA_W-1:0] dataBusIn,    // data_bus sensed
  output logic                        reqReady,     // idle, may take request
  output logic                        rspValid,     // read data pulse
  output logic [`BBS_DATA_W-1:0]      rspData,      // read byte
  output logic                        powerOk,      // accesses allowed
  output logic [`BBS_ADDR_W-1:0]      addrBus,      // addr_bus
  output logic [`BBS_DATA_W-1:0]      dataBusOut,   // data_bus drive value
  output logic                        dataBusOe,    // data_bus drive enable
  output logic                        chipSel_n,    // chip select, low
  output logic                        writeStb_n,   // write strobe, low
  output logic                        outGate_n     // output gate, low
);
  bbs_state_type state;
  logic          isWrite;
  logic          timerLoad;
  logic [15:0]   timerValue;
  logic          timerDone;
  logic          cycLoad;
  logic          cycDone;
  logic          recLoad;
  logic          recDone;
  logic          supplyNormal;
  logic          accept;
  logic          abort;

  // ***************************************************************
  // supply tracking
  // ***************************************************************
  assign supplyNormal = (bbs_supply_type'(supplyState) == BBS_SUPPLY_NORMAL);
  assign abort        = !supplyNormal && state != BBS_IDLE;
  assign recLoad      = !supplyNormal;
  // supply check here too: reqReady is a cycle old when the supply drops
  assign accept       = (state == BBS_IDLE) && reqValid && reqReady && cycDone && supplyNormal;
  assign cycLoad      = accept;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      powerOk <= 1'b0;
    end else begin
      // warning stops new work early; supply loss stops everything
      powerOk <= supplyNormal && recDone && failWarn_n;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reqReady <= 1'b0;
    end else begin
      reqReady <= powerOk && (state == BBS_IDLE) && !accept && supplyNormal;
    end
  end

  // ***************************************************************
  // access sequencer
  // ***************************************************************
  always_comb begin
    timerLoad  = 1'b0;
    timerValue = 16'h0000;
    case (state)
      BBS_IDLE: begin
        if (accept) begin
          timerLoad  = 1'b1;
          timerValue = reqWrite ? 16'(`BBS_FLOAT_CYC) : 16'(`BBS_ACCESS_CYC);
        end
      end
      BBS_WR_FLT: begin
        if (timerDone) begin
          timerLoad  = 1'b1;
          timerValue = 16'(`BBS_PULSE_CYC);
        end
      end
      BBS_RD_WAIT, BBS_WR_PULS: begin
        if (timerDone) begin
          timerLoad  = 1'b1;
          timerValue = 16'(`BBS_GFLOAT_CYC);
        end
      end
      BBS_FLOAT: begin
        if (timerDone) begin
          timerLoad  = 1'b1;
          timerValue = 16'(`BBS_RECOVERY_CYC);
        end
      end
      default: begin
        timerLoad  = 1'b0;
        timerValue = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state   <= BBS_IDLE;
      isWrite <= 1'b0;
    end else if (abort) begin
      state <= BBS_FLOAT;
    end else begin
      case (state)
        BBS_IDLE: begin
          if (accept) begin
            isWrite <= reqWrite;
            state   <= reqWrite ? BBS_WR_FLT : BBS_RD_WAIT;
          end
        end
        BBS_RD_WAIT: if (timerDone) state <= BBS_FLOAT;
        BBS_WR_FLT:  if (timerDone) state <= BBS_WR_PULS;
        BBS_WR_PULS: if (timerDone) state <= BBS_FLOAT;
        BBS_FLOAT:   if (timerDone) state <= BBS_RECOVER;
        BBS_RECOVER: if (timerDone) state <= BBS_IDLE;
        default: state <= BBS_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // pins
  // ***************************************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      chipSel_n  <= 1'b1;
      writeStb_n <= 1'b1;
      outGate_n  <= 1'b1;
      addrBus    <= `BBS_ADDR_RESET;
    end else if (abort) begin
      chipSel_n  <= 1'b1;
      writeStb_n <= 1'b1;
      outGate_n  <= 1'b1;
    end else if (accept) begin
      addrBus    <= reqAddr;
      chipSel_n  <= 1'b0;
      writeStb_n <= !reqWrite;
      outGate_n  <= reqWrite;
    end else if (timerDone && (state == BBS_RD_WAIT || state == BBS_WR_PULS)) begin
      chipSel_n  <= 1'b1;
      writeStb_n <= 1'b1;
      outGate_n  <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dataBusOe  <= 1'b0;
      dataBusOut <= `BBS_DATA_RESET;
    end else if (abort) begin
      dataBusOe <= 1'b0;
    end else if (state == BBS_WR_FLT && timerDone) begin
      dataBusOe  <= 1'b1;      // byte was latched at take
    end else if (accept) begin
      dataBusOut <= reqData;
    end else if (state == BBS_FLOAT && timerDone) begin
      dataBusOe <= 1'b0;       // hold past strobe rise
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rspValid <= 1'b0;
      rspData  <= `BBS_DATA_RESET;
    end else begin
      rspValid <= 1'b0;
      if (state == BBS_RD_WAIT && timerDone && !abort && !isWrite) begin
        rspValid <= 1'b1;
        rspData  <= dataBusIn;
      end
    end
  end

  // ***************************************************************
  // timers
  // ***************************************************************
  bbs_delay_count #(.WIDTH(16)) uStepTimer (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .load    (timerLoad),
    .value   (timerValue),
    .done    (timerDone)
  );

  bbs_delay_count #(.WIDTH(16)) uCycleTimer (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .load    (cycLoad),
    .value   (16'(`BBS_CYCLE_CYC)),
    .done    (cycDone)
  );

  // recovery timer; reset clears it, so it loads only while the supply check sees a supply that is not normal
  bbs_delay_count #(.WIDTH(17)) uRecoverTimer (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .load    (recLoad),
    .value   (17'(POWER_REC_CYC)),
    .done    (recDone)
  );
endmodule

// >>> bbs_host_assertions.sv
`include "bbsram_cfg.svh"
module bbs_host_chk (
  input wire logic                   sys_clk,     // clock
  input wire logic                   nrst,        // reset, low
  input wire logic [1:0]             supplyState, // supply state
  input wire logic                   powerOk,     // access allowed
  input wire logic                   rspValid,    // read pulse
  input wire logic [`BBS_ADDR_W-1:0] addrBus,     // address pins
  input wire logic                   dataBusOe,   // host drives data
  input wire logic                   chipSel_n,   // select, low
  input wire logic                   writeStb_n,  // write strobe, low
  input wire logic                   outGate_n    // output gate, low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] gap;
  logic [7:0] stbAge;
  // ********
  // select spacing, saturates so long idle never wraps
  // ********
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) gap <= 8'hff;
    else if ($fell(chipSel_n)) gap <= 8'h01;
    else if (gap != 8'hff) gap <= gap + 8'h01;
  end
  // cycles since the write strobe fell, saturating
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) stbAge <= 8'h00;
    else if ($fell(writeStb_n)) stbAge <= 8'h01;
    else if (stbAge != 8'hff) stbAge <= stbAge + 8'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_cycleGap; $fell(chipSel_n) |-> gap >= 8'h3f; endproperty
  a_cycleGap: assert property (p_cycleGap) else $error("accesses too close");
  property p_addrHold; (!chipSel_n && !writeStb_n)[*2] |-> $stable(addrBus); endproperty
  a_addrHold: assert property (p_addrHold) else $error("address moved in write");
  property p_gateInWrite; !writeStb_n |-> outGate_n; endproperty
  a_gateInWrite: assert property (p_gateInWrite) else $error("gate low in write");
  property p_noEarlyDrive; $fell(writeStb_n) |-> !dataBusOe [*8]; endproperty
  a_noEarlyDrive: assert property (p_noEarlyDrive) else $error("bus driven early");
  property p_floatWait; $rose(dataBusOe) |-> stbAge >= 8'h14; endproperty
  a_floatWait: assert property (p_floatWait) else $error("bus driven before float");
  property p_dataSetup;
    $rose(writeStb_n) && supplyState == 2'h0 |-> $past(dataBusOe, 25) && dataBusOe ##1 dataBusOe;
  endproperty
  a_dataSetup: assert property (p_dataSetup) else $error("write data window short");
  property p_recover; $rose(chipSel_n) |-> chipSel_n [*3]; endproperty
  a_recover: assert property (p_recover) else $error("select recovery short");
  property p_readAccess;
    rspValid |-> $past(!chipSel_n && !outGate_n && writeStb_n, 63);
  endproperty
  a_readAccess: assert property (p_readAccess) else $error("read sampled early");
  property p_supplyDrop;
    supplyState != 2'h0 |=> chipSel_n && writeStb_n && !dataBusOe && !powerOk;
  endproperty
  a_supplyDrop: assert property (p_supplyDrop) else $error("access in low supply");
endmodule
bind bbs_host bbs_host_chk i_bbs_host_chk (.sys_clk, .nrst, .supplyState, .powerOk,
  .rspValid, .addrBus, .dataBusOe, .chipSel_n, .writeStb_n, .outGate_n);

// >>> bbs_sram_model.sv
`include "bbsram_cfg.svh"
module bbs_sram_model
  import bbs_pkg::*;
#(
  parameter int ACC_NS   = 200, // read access, ns
  parameter int FLT_NS   = 50,  // output float, ns
  parameter bit LOW_BATT = 1'b0 // low battery seen at power-up
) (
  input  wire logic [`BBS_ADDR_W-1:0] addrBus,     // address
  input  wire logic [`BBS_DATA_W-1:0] dataBusOut,  // host drive value
  input  wire logic                   dataBusOe,   // host drives
  input  wire logic                   chipSel_n,   // select, low
  input  wire logic                   writeStb_n,  // write strobe, low
  input  wire logic                   outGate_n,   // output gate, low
  input  wire logic [1:0]             supplyState, // supply state
  output logic      [`BBS_DATA_W-1:0] dataBusIn    // resolved bus
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [`BBS_DATA_W-1:0] mem [0:2047];
  logic [`BBS_DATA_W-1:0] outVal;
  logic                   drive = 1'b0;
  logic                   blockWr = LOW_BATT;
  logic                   active, gateOn, wrOn;
  assign active = supplyState == BBS_SUPPLY_NORMAL;
  assign gateOn = active && !chipSel_n && writeStb_n && !outGate_n;
  assign wrOn = active && !chipSel_n && !writeStb_n;
  // old byte holds briefly, then garbage until access time
  always @(addrBus or gateOn) begin
    outVal <= #15 ~outVal;
    outVal <= #(ACC_NS) mem[addrBus];
  end
  always @(gateOn) drive <= #(gateOn ? 0 : FLT_NS) gateOn;
  // contention shows as unknown, released bus shows inverted byte
  assign dataBusIn = dataBusOe ? (drive ? {`BBS_DATA_W{1'bx}} : dataBusOut)
                               : (drive ? outVal : ~outVal);
  // supply loss ends the write without storing
  always @(negedge wrOn) begin
    if (active) begin
      if (blockWr) blockWr = 1'b0;
      else mem[addrBus] = dataBusIn;
    end
  end
endmodule

// >>> bbs_host_tb.sv
`include "bbsram_cfg.svh"
module bbs_host_tb;
  import bbs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int REC = 20;
  logic                   sys_clk = 1'b0, nrst = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
  logic                   failWarn_n = 1'b1;
  logic [1:0]             supplyState = 2'h0;
  logic [`BBS_ADDR_W-1:0] reqAddr = 11'h000, addrBus;
  logic [`BBS_DATA_W-1:0] reqData = 8'h00, dataBusIn, dataBusOut, rspData;
  logic                   reqReady, rspValid, powerOk, dataBusOe;
  logic                   chipSel_n, writeStb_n, outGate_n;
  logic [`BBS_DATA_W-1:0] shadow [0:2047];
  logic [`BBS_DATA_W-1:0] expQ [$];
  logic [`BBS_ADDR_W-1:0] adr [0:7];
  logic [31:0]            seed = 32'h0001_63c4; // 91076
  int                     numErrors = 0, cmpCount = 0, n;
  bbs_host #(.POWER_REC_CYC(REC)) i_bbs_host (.sys_clk, .nrst, .reqValid, .reqWrite,
    .reqAddr, .reqData, .supplyState, .failWarn_n, .dataBusIn, .reqReady, .rspValid,
    .rspData, .powerOk, .addrBus, .dataBusOut, .dataBusOe, .chipSel_n, .writeStb_n,
    .outGate_n);
  bbs_sram_model #(.ACC_NS(250)) i_bbs_sram_model (.addrBus, .dataBusOut, .dataBusOe,
    .chipSel_n, .writeStb_n, .outGate_n, .supplyState, .dataBusIn);
  initial forever #2 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic completeRun();
    $display("errors %0d, compares %0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // ********
  // one access; expectation noted when the request is offered
  // ********
  task automatic access(input logic w, input logic [10:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (reqReady !== 1'b1 && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr = a;
    reqData = d;
    if (w) shadow[a] = d;
    else expQ.push_back(shadow[a]);
    while (reqReady === 1'b1 && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    reqValid = 1'b0;
    if (k >= 400) begin
      numErrors++;
      completeRun();
    end
  endtask
  always @(negedge sys_clk) begin
    if (rspValid === 1'b1) begin
      if (expQ.size() == 0) begin
        numErrors++;
        $display("ERROR %0t: unexpected read data", $time);
      end else check(rspData, expQ.pop_front());
    end
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    check({6'h00, chipSel_n, writeStb_n}, 8'h03);
    check({7'h00, dataBusOe}, 8'h00);
    nrst = 1'b1;
    // corners and an overwrite of address zero, read back newest first
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      adr[i] = (i == 1) ? 11'h7ff : (i < 3) ? 11'h000 : seed[10:0];
      access(1'b1, adr[i], seed[23:16]);
    end
    for (int i = 7; i >= 0; i--) access(1'b0, adr[i], 8'h00);
    // warning blocks new requests
    failWarn_n = 1'b0;
    repeat (100) @(negedge sys_clk);
    reqValid = 1'b1;
    repeat (70) @(negedge sys_clk);
    check({6'h00, chipSel_n, powerOk}, 8'h02);
    reqValid = 1'b0;
    failWarn_n = 1'b1;
    // supply loss in mid-write keeps the old byte
    access(1'b1, 11'h055, 8'ha5);
    access(1'b1, 11'h055, 8'h3c);
    shadow[11'h055] = 8'ha5;
    repeat (8) @(negedge sys_clk);
    supplyState = BBS_SUPPLY_FAIL;
    @(negedge sys_clk);
    check({6'h00, chipSel_n, writeStb_n}, 8'h03);
    repeat (10) @(negedge sys_clk);
    supplyState = BBS_SUPPLY_BATTERY;
    repeat (10) @(negedge sys_clk);
    check({6'h00, chipSel_n, powerOk}, 8'h02);
    supplyState = BBS_SUPPLY_NORMAL;
    n = 0;
    while (powerOk !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    check({7'h00, (n >= REC && n < 100)}, 8'h01);
    access(1'b0, 11'h055, 8'h00);
    n = 0;
    while (expQ.size() != 0 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 400) numErrors++;
    completeRun();
  end
endmodule
